// *** logic/ppfs_top.sv ***
// port pin-function select: port registers, function routing of shared pads, wake-up
// assumes apb master on pclk; pwm levels arrive on pclk; pads are asynchronous
// Overview of operation
// RULE1: analogue variant: pad PA3 bit 6 chooses port/interrupt or analogue channel 3
// RULE2: analogue variant: pad PA2 bit 4 chooses port/timer clock or analogue channel 2
// RULE3: analogue variant: PA1 field bits 3..2 chooses port, inverted pwm a, vref, channel 1
// RULE4: analogue variant: PA0 field bits 1..0 chooses port, pwm a, channel 0, port
// RULE5: PA6 bit 4 of high select chooses port/interrupt or pwm c
// RULE6: PA4 bit 0 of high select chooses port or pwm a
// RULE7: PA5 uses bit 2 (reduced) or bits 3..2 with channel 4 (analogue)
// RULE8: port b bit 5 routes pad PB5 to port or pwm a
// RULE9: port b bit 1 routes pad PB1 to port or pwm c
// RULE10: port b bit 0 routes pad PB0 to port or pwm b
// RULE11: interrupt source bit 0 picks pad PA3 or pad PA6 for interrupt input
// RULE12: unimplemented select bits read zero and ignore writes
// RULE13: reset sets all port data and direction bits to ones
// RULE14: output enabled before data rewrite drives high
// RULE15: bit set/clear reads the whole port, changes one bit, writes byte back
// RULE16: while sleeping, falling edge on wake-enabled port a pin wakes device
// RULE17: direction 1 makes an input reading pad, 0 a push-pull output from latch
// RULE18: a pad given to a peripheral or analogue path is not driven by the latch
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "ppfs_params.svh"
module ppfs_top import ppfs_pkg::*; #(
    parameter bit ANALOG_VARIANT = 1'b1
) (
    // clock and reset
    input  wire  logic        pclk,
    input  wire  logic        presetn,
    // apb slave
    input  wire  logic        psel,
    input  wire  logic        penable,
    input  wire  logic        pwrite,
    input  wire  logic [11:0] paddr,
    input  wire  logic [31:0] pwdata,
    output logic              pready,
    output logic              pslverr,
    output logic       [31:0] prdata,
    // pads
    input  wire  logic [7:0]  pa_in,
    input  wire  logic [7:0]  pb_in,
    output ppfs_pads_s        pa_pads,
    output ppfs_pads_s        pb_pads,
    // peripheral outputs
    input  wire  logic        pwm_a_output,
    input  wire  logic        pwm_a_inverted_output,
    input  wire  logic        pwm_b_output,
    input  wire  logic        pwm_c_output,
    // peripheral inputs and analogue
    output logic              ext_int_input,
    output logic              timer_clock_input,
    output ppfs_ana_s         analog_conn,
    // power management
    input  wire  logic        sleep_mode,
    output logic              wake_up
);

    // software registers
    logic [7:0] pa_data_q;
    logic [7:0] pa_dir_q;
    logic [7:0] pb_data_q;
    logic [7:0] pb_dir_q;
    logic [7:0] pa_wake_q;
    logic [7:0] pas_low_q;
    logic [7:0] pas_high_q;
    logic [7:0] pbs_q;
    logic [7:0] int_src_q;
    logic [7:0] pa_prev_q;

    // synchronised pads
    logic [7:0] pa_sync;
    logic [7:0] pb_sync;

    // decoded wires
    logic        wr_acc;
    logic        rd_setup;
    logic        addr_hit;
    logic [7:0]  mask_low;
    logic [7:0]  mask_high;
    logic [7:0]  pa_view;
    logic [7:0]  pb_view;
    logic [2:0]  bop_bit;
    logic [1:0]  bop_tgt;
    logic        bop_set;
    logic        bop_wr;
    logic [7:0]  bop_src;
    logic [7:0]  bop_val;
    logic [31:0] rd_mux;
    logic [7:0]  pa_fall;
    logic [7:0]  pa_drive_d;
    logic [7:0]  pa_level_d;
    logic [7:0]  pb_drive_d;
    logic [7:0]  pb_level_d;
    logic        int_d;
    ppfs_ana_s   ana_d;

    ppfs_route_s route_a [8];
    ppfs_route_s route_b [8];

    // address match
    function automatic logic at(input logic [11:0] a, input logic [11:0] off);
        at = (a == off);
    endfunction

    // write strobe of one register
    function automatic logic wr_to(input logic en, input logic [11:0] a, input logic [11:0] off);
        wr_to = en && at(a, off);
    endfunction

    // pad synchronisers
    ppfs_sync #(
        .W        (16)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({pb_in, pa_in}),
        .sync_out ({pb_sync, pa_sync})
    );

    // apb handshake: read data latched in setup, writes and answer in first access cycle
    assign pready   = psel && penable;
    assign pslverr  = pready && !addr_hit;
    assign wr_acc   = pready && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign addr_hit = at(paddr, `PPFS_OFF_PA_DATA)  || at(paddr, `PPFS_OFF_PA_DIR)
                   || at(paddr, `PPFS_OFF_PB_DATA)  || at(paddr, `PPFS_OFF_PB_DIR)
                   || at(paddr, `PPFS_OFF_PA_WAKE)  || at(paddr, `PPFS_OFF_PAS_LOW)
                   || at(paddr, `PPFS_OFF_PAS_HIGH) || at(paddr, `PPFS_OFF_PBS)
                   || at(paddr, `PPFS_OFF_INT_SRC)  || at(paddr, `PPFS_OFF_BIT_OP)
                   || at(paddr, `PPFS_OFF_PA_PAD)   || at(paddr, `PPFS_OFF_PB_PAD);

    // variant masks on the select registers
    assign mask_low  = ANALOG_VARIANT ? `PPFS_MASK_PAS_LOW_ANA : `PPFS_MASK_PAS_LOW_RED;   // RULE12
    assign mask_high = ANALOG_VARIANT ? `PPFS_MASK_PAS_HIGH_ANA : `PPFS_MASK_PAS_HIGH_RED; // RULE12

    // port view: input bits show pad, output bits show latch
    assign pa_view = (pa_dir_q & pa_sync) | (~pa_dir_q & pa_data_q); // RULE17
    assign pb_view = (pb_dir_q & pb_sync) | (~pb_dir_q & pb_data_q); // RULE17

    // bit set/clear: read whole target, change one bit, write byte back
    assign bop_bit = pwdata[`PPFS_BOP_BIT_LSB +: 3];
    assign bop_tgt = pwdata[`PPFS_BOP_TGT_LSB +: 2];
    assign bop_set = pwdata[`PPFS_BOP_SET_BIT];
    assign bop_wr  = wr_to(wr_acc, paddr, `PPFS_OFF_BIT_OP);
    assign bop_src = (bop_tgt == PPFS_TGT_PA_DATA) ? pa_view :
                     (bop_tgt == PPFS_TGT_PA_DIR)  ? pa_dir_q :
                     (bop_tgt == PPFS_TGT_PB_DATA) ? pb_view : pb_dir_q; // RULE15
    assign bop_val = bop_set ? (bop_src | (8'h01 << bop_bit))
                             : (bop_src & ~(8'h01 << bop_bit)); // RULE15

    // read multiplexer
    assign rd_mux = at(paddr, `PPFS_OFF_PA_DATA)  ? 32'(pa_view) :
                    at(paddr, `PPFS_OFF_PA_DIR)   ? 32'(pa_dir_q) :
                    at(paddr, `PPFS_OFF_PB_DATA)  ? 32'(pb_view) :
                    at(paddr, `PPFS_OFF_PB_DIR)   ? 32'(pb_dir_q) :
                    at(paddr, `PPFS_OFF_PA_WAKE)  ? 32'(pa_wake_q) :
                    at(paddr, `PPFS_OFF_PAS_LOW)  ? 32'(pas_low_q) :
                    at(paddr, `PPFS_OFF_PAS_HIGH) ? 32'(pas_high_q) :
                    at(paddr, `PPFS_OFF_PBS)      ? 32'(pbs_q) :
                    at(paddr, `PPFS_OFF_INT_SRC)  ? 32'(int_src_q) :
                    at(paddr, `PPFS_OFF_PA_PAD)   ? 32'(pa_sync) :
                    at(paddr, `PPFS_OFF_PB_PAD)   ? 32'(pb_sync) : 32'h00000000;

    // port data and direction registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pa_data_q <= `PPFS_RST_PORT; // RULE13 RULE14
            pa_dir_q  <= `PPFS_RST_PORT; // RULE13
            pb_data_q <= `PPFS_RST_PORT; // RULE13 RULE14
            pb_dir_q  <= `PPFS_RST_PORT; // RULE13
        end
        else
        begin
            if (wr_to(wr_acc, paddr, `PPFS_OFF_PA_DATA))
                pa_data_q <= pwdata[7:0];
            else if (bop_wr && bop_tgt == PPFS_TGT_PA_DATA)
                pa_data_q <= bop_val; // RULE15
            if (wr_to(wr_acc, paddr, `PPFS_OFF_PA_DIR))
                pa_dir_q <= pwdata[7:0];
            else if (bop_wr && bop_tgt == PPFS_TGT_PA_DIR)
                pa_dir_q <= bop_val; // RULE15
            if (wr_to(wr_acc, paddr, `PPFS_OFF_PB_DATA))
                pb_data_q <= pwdata[7:0];
            else if (bop_wr && bop_tgt == PPFS_TGT_PB_DATA)
                pb_data_q <= bop_val; // RULE15
            if (wr_to(wr_acc, paddr, `PPFS_OFF_PB_DIR))
                pb_dir_q <= pwdata[7:0];
            else if (bop_wr && bop_tgt == PPFS_TGT_PB_DIR)
                pb_dir_q <= bop_val; // RULE15
        end
    end

    // select and wake-enable registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pa_wake_q  <= 8'h00;
            pas_low_q  <= `PPFS_RST_SEL;
            pas_high_q <= `PPFS_RST_SEL;
            pbs_q      <= `PPFS_RST_SEL;
            int_src_q  <= `PPFS_RST_SEL;
        end
        else
        begin
            if (wr_to(wr_acc, paddr, `PPFS_OFF_PA_WAKE))
                pa_wake_q <= pwdata[7:0];
            if (wr_to(wr_acc, paddr, `PPFS_OFF_PAS_LOW))
                pas_low_q <= pwdata[7:0] & mask_low; // RULE12
            if (wr_to(wr_acc, paddr, `PPFS_OFF_PAS_HIGH))
                pas_high_q <= pwdata[7:0] & mask_high; // RULE12
            if (wr_to(wr_acc, paddr, `PPFS_OFF_PBS))
                pbs_q <= pwdata[7:0] & `PPFS_MASK_PBS; // RULE12
            if (wr_to(wr_acc, paddr, `PPFS_OFF_INT_SRC))
                int_src_q <= pwdata[7:0] & `PPFS_MASK_INT_SRC; // RULE12
        end
    end

    // port a routes; masked bits make the reduced variant fall out of the same decode
    assign route_a[0] = '{periph: pas_low_q[1:0] == 2'b01, value: pwm_a_output,
                          analog: pas_low_q[1:0] == 2'b10}; // RULE4
    assign route_a[1] = '{periph: pas_low_q[3:2] == 2'b01, value: pwm_a_inverted_output,
                          analog: pas_low_q[3]}; // RULE3
    assign route_a[2] = '{periph: 1'b0, value: 1'b0, analog: pas_low_q[4]}; // RULE2
    assign route_a[3] = '{periph: 1'b0, value: 1'b0, analog: pas_low_q[6]}; // RULE1
    assign route_a[4] = '{periph: pas_high_q[0], value: pwm_a_output, analog: 1'b0}; // RULE6
    assign route_a[5] = '{periph: pas_high_q[3:2] == 2'b01, value: pwm_b_output,
                          analog: pas_high_q[3:2] == 2'b10}; // RULE7
    assign route_a[6] = '{periph: pas_high_q[4], value: pwm_c_output, analog: 1'b0}; // RULE5
    assign route_a[7] = '{periph: 1'b0, value: 1'b0, analog: 1'b0};

    // port b routes
    assign route_b[0] = '{periph: pbs_q[0], value: pwm_b_output, analog: 1'b0}; // RULE10
    assign route_b[1] = '{periph: pbs_q[1], value: pwm_c_output, analog: 1'b0}; // RULE9
    assign route_b[2] = '{periph: 1'b0, value: 1'b0, analog: 1'b0};
    assign route_b[3] = '{periph: 1'b0, value: 1'b0, analog: 1'b0};
    assign route_b[4] = '{periph: 1'b0, value: 1'b0, analog: 1'b0};
    assign route_b[5] = '{periph: pbs_q[5], value: pwm_a_output, analog: 1'b0}; // RULE8
    assign route_b[6] = '{periph: 1'b0, value: 1'b0, analog: 1'b0};
    assign route_b[7] = '{periph: 1'b0, value: 1'b0, analog: 1'b0};

    // per-pad drive: peripheral, else analogue (released), else latch by direction
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_pad
            assign pa_drive_d[gi] = route_a[gi].periph || (!route_a[gi].analog && !pa_dir_q[gi]); // RULE17 RULE18
            assign pa_level_d[gi] = route_a[gi].periph ? route_a[gi].value : pa_data_q[gi]; // RULE18
            assign pb_drive_d[gi] = route_b[gi].periph || (!route_b[gi].analog && !pb_dir_q[gi]); // RULE17 RULE18
            assign pb_level_d[gi] = route_b[gi].periph ? route_b[gi].value : pb_data_q[gi]; // RULE18
        end
    endgenerate

    // analogue connections and interrupt source
    assign ana_d.chan = {route_a[5].analog, route_a[3].analog, route_a[2].analog,
                         pas_low_q[3:2] == 2'b11, route_a[0].analog}; // RULE1 RULE2 RULE3 RULE4 RULE7
    assign ana_d.vref = (pas_low_q[3:2] == 2'b10); // RULE3
    assign int_d      = int_src_q[0] ? pa_sync[6] : pa_sync[3]; // RULE11

    // falling edges on port a
    assign pa_fall = pa_prev_q & ~pa_sync;

    // registered pad, peripheral and wake outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pa_pads           <= '0;
            pb_pads           <= '0;
            analog_conn       <= '0;
            ext_int_input     <= 1'b0;
            timer_clock_input <= 1'b0;
            pa_prev_q         <= 8'h00;
            wake_up           <= 1'b0;
        end
        else
        begin
            pa_pads.out       <= pa_level_d;
            pa_pads.oe        <= pa_drive_d;
            pb_pads.out       <= pb_level_d;
            pb_pads.oe        <= pb_drive_d;
            analog_conn       <= ana_d;
            ext_int_input     <= int_d;      // RULE11
            timer_clock_input <= pa_sync[2]; // RULE2
            pa_prev_q         <= pa_sync;
            wake_up           <= sleep_mode && |(pa_fall & pa_wake_q); // RULE16
        end
    end

    // read data captured in setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (rd_setup)
            prdata <= rd_mux;
    end

endmodule // ppfs_top
`default_nettype wire

// *** logic/ppfs_params.svh ***
// constants of the port pin-function select block
// assumes inclusion by bare name from the top module, the checker and the testbench
`ifndef PPFS_PARAMS_SVH
`define PPFS_PARAMS_SVH

// register byte offsets on the apb bus
`define PPFS_OFF_PA_DATA    12'h000
`define PPFS_OFF_PA_DIR     12'h004
`define PPFS_OFF_PB_DATA    12'h008
`define PPFS_OFF_PB_DIR     12'h00c
`define PPFS_OFF_PA_WAKE    12'h010
`define PPFS_OFF_PAS_LOW    12'h014
`define PPFS_OFF_PAS_HIGH   12'h018
`define PPFS_OFF_PBS        12'h01c
`define PPFS_OFF_INT_SRC    12'h020
`define PPFS_OFF_BIT_OP     12'h024
`define PPFS_OFF_PA_PAD     12'h028
`define PPFS_OFF_PB_PAD     12'h02c

// implemented bits per variant
`define PPFS_MASK_PAS_LOW_ANA   8'h5f
`define PPFS_MASK_PAS_LOW_RED   8'h05
`define PPFS_MASK_PAS_HIGH_ANA  8'h1d
`define PPFS_MASK_PAS_HIGH_RED  8'h15
`define PPFS_MASK_PBS           8'h23
`define PPFS_MASK_INT_SRC       8'h01

// reset values
`define PPFS_RST_PORT       8'hff
`define PPFS_RST_SEL        8'h00

// bit-operation command fields
`define PPFS_BOP_BIT_LSB    0
`define PPFS_BOP_TGT_LSB    4
`define PPFS_BOP_SET_BIT    8

`endif

// *** logic/ppfs_pkg.sv ***
// types of the port pin-function select block
// assumes the params header sits beside it
package ppfs_pkg;

    // route of one pad: who drives it and with what
    typedef struct packed {
        logic periph;   // peripheral output owns the pad
        logic value;    // peripheral output level
        logic analog;   // analogue path owns the pad
    } ppfs_route_s;

    // drive of one port's pads
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } ppfs_pads_s;

    // analogue connections towards the converter
    typedef struct packed {
        logic [4:0] chan;   // channel n connected
        logic       vref;   // reference input connected
    } ppfs_ana_s;

    // bit-operation target
    typedef enum logic [1:0] {
        PPFS_TGT_PA_DATA = 2'b00,
        PPFS_TGT_PA_DIR  = 2'b01,
        PPFS_TGT_PB_DATA = 2'b10,
        PPFS_TGT_PB_DIR  = 2'b11
    } ppfs_target_e;

endpackage

// *** logic/ppfs_sync.sv ***
// two-flop synchroniser for pad inputs
// assumes the input is asynchronous to pclk
`timescale 1ns/100ps
`default_nettype none
module ppfs_sync #(
    parameter int W = 8
) (
    // clock and reset
    input  wire  logic         pclk,
    input  wire  logic         presetn,
    // data
    input  wire  logic [W-1:0] async_in,
    output logic       [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // ppfs_sync
`default_nettype wire

// *** verification/ppfs_pad_model.sv ***
// pad side model: outside circuit and pwm sources
// assumes pad enable high means the block drives the pad; pads carry no pull
`timescale 1ns/100ps
`default_nettype none
module ppfs_pad_model import ppfs_pkg::*; (
    // clock
    input  wire logic       pclk,
    // block pad drive and outside levels
    input  wire ppfs_pads_s pa_pads,
    input  wire ppfs_pads_s pb_pads,
    input  wire logic [7:0] pa_ext,
    input  wire logic [7:0] pb_ext,
    // resolved pad levels
    output logic      [7:0] pa_in,
    output logic      [7:0] pb_in,
    // pwm levels, distinct rates so a wrong route shows
    output logic            pwm_a_output,
    output logic            pwm_a_inverted_output,
    output logic            pwm_b_output,
    output logic            pwm_c_output
);
    logic [3:0] cnt_q = 4'h0;

    // block drive wins where enabled, else the outside level
    assign pa_in = (pa_pads.oe & pa_pads.out) | (~pa_pads.oe & pa_ext);
    assign pb_in = (pb_pads.oe & pb_pads.out) | (~pb_pads.oe & pb_ext);

    // free-running pattern behind the pwm levels
    always @(posedge pclk)
        cnt_q <= cnt_q + 4'h1;
    assign pwm_a_output          = cnt_q[1];
    assign pwm_a_inverted_output = cnt_q[2];
    assign pwm_b_output          = cnt_q[0];
    assign pwm_c_output          = cnt_q[3];
endmodule // ppfs_pad_model
`default_nettype wire

// *** verification/ppfs_top_chk.sv ***
// port checker of the pin-function select block, bound into ppfs_top
// assumes zero-wait apb
`timescale 1ns/100ps
`default_nettype none
`include "ppfs_params.svh"
module ppfs_top_chk import ppfs_pkg::*; #(
    parameter bit ANALOG_VARIANT = 1'b1
) (
    // clock, reset and apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // pads, peripherals, power
    input wire logic [7:0]  pa_in,
    input wire ppfs_pads_s  pa_pads,
    input wire ppfs_pads_s  pb_pads,
    input wire logic        pwm_a_output,
    input wire logic        ext_int_input,
    input wire logic        timer_clock_input,
    input wire ppfs_ana_s   analog_conn,
    input wire logic        sleep_mode,
    input wire logic        wake_up
);
    logic [7:0] low_q, high_q, pbs_q, wake_q, pa_prev_q;
    logic       int_q;
    logic [2:0] cnt_q;

    // shadow copies of the select and wake registers
    wire       wr_w      = psel & penable & pwrite;
    wire [7:0] low_d     = (wr_w && paddr == `PPFS_OFF_PAS_LOW) ? pwdata[7:0] : low_q;
    wire [7:0] high_d    = (wr_w && paddr == `PPFS_OFF_PAS_HIGH) ? pwdata[7:0] : high_q;
    wire [7:0] pbs_d     = (wr_w && paddr == `PPFS_OFF_PBS) ? pwdata[7:0] : pbs_q;
    wire [7:0] wake_d    = (wr_w && paddr == `PPFS_OFF_PA_WAKE) ? pwdata[7:0] : wake_q;
    wire       int_d     = (wr_w && paddr == `PPFS_OFF_INT_SRC) ? pwdata[0] : int_q;
    wire [2:0] cnt_d     = (cnt_q == 3'h7) ? cnt_q : cnt_q + 3'h1;
    wire       int_pad_w = int_q ? pa_in[6] : pa_in[3];
    wire       fall_w    = |(wake_q & pa_prev_q & ~pa_in);

    // shadow state; cycle count saturates
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {low_q, high_q, pbs_q, wake_q, pa_prev_q, int_q, cnt_q} <= '0;
        else
            {low_q, high_q, pbs_q, wake_q, pa_prev_q, int_q, cnt_q} <=
                {low_d, high_d, pbs_d, wake_d, pa_in, int_d, cnt_d};
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_reset_pads: assert property (
        cnt_q == 3'h1 |-> pa_pads == {8'hff, 8'h00} && pb_pads == {8'hff, 8'h00})
        else $error("pads not released high after reset");
    chk_pa0_analog: assert property (
        ANALOG_VARIANT && low_q[1:0] == 2'b10 && $stable(low_q) |=> !pa_pads.oe[0] && analog_conn.chan[0])
        else $error("pad0 not handed to channel 0");
    chk_pa3_analog: assert property (
        ANALOG_VARIANT && low_q[6] && $stable(low_q) |=> !pa_pads.oe[3] && analog_conn.chan[3])
        else $error("pad3 not handed to channel 3");
    chk_pa4_pwm: assert property (
        high_q[0] && $stable(high_q) |=> pa_pads.oe[4] && pa_pads.out[4] == $past(pwm_a_output))
        else $error("pad4 not driven by pwm a");
    chk_pb5_pwm: assert property (
        pbs_q[5] && $stable(pbs_q) |=> pb_pads.oe[5] && pb_pads.out[5] == $past(pwm_a_output))
        else $error("port b pad5 not driven by pwm a");
    chk_int_source: assert property (
        cnt_q == 3'h7 && int_q == $past(int_q, 4) |-> ext_int_input == $past(int_pad_w, 3))
        else $error("interrupt input from wrong pad");
    chk_timer_clock: assert property (
        cnt_q == 3'h7 |-> timer_clock_input == $past(pa_in[2], 3))
        else $error("timer clock does not follow pad2");
    chk_wake_fall: assert property (
        fall_w && sleep_mode ##1 sleep_mode [*2] |=> wake_up)
        else $error("enabled falling edge did not wake");
    chk_wake_asleep: assert property (
        wake_up |-> $past(sleep_mode))
        else $error("wake pulse while awake");
    chk_pbs_unimpl: assert property (
        psel && penable && !pwrite && paddr == `PPFS_OFF_PBS |->
        prdata[31:8] == 24'h0 && (prdata[7:0] & ~`PPFS_MASK_PBS) == 8'h00)
        else $error("unused port b select bits read nonzero");
endmodule // ppfs_top_chk

bind ppfs_top ppfs_top_chk #(.ANALOG_VARIANT(ANALOG_VARIANT)) u_chk (.*);
`default_nettype wire

// *** verification/tb_top.sv ***
// testbench of the pin-function select block: apb master, pad model, scenarios
// assumes the analogue variant
`timescale 1ns/100ps
`default_nettype none
`include "ppfs_params.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb_top import ppfs_pkg::*;;
    localparam logic [11:0] LO = `PPFS_OFF_PAS_LOW;
    localparam logic [11:0] HI = `PPFS_OFF_PAS_HIGH;
    localparam logic [11:0] PB = `PPFS_OFF_PBS;
    localparam logic [11:0] IS = `PPFS_OFF_INT_SRC;
    localparam logic [11:0] SA [4] = '{LO, HI, PB, IS};
    localparam logic [7:0]  SM [4] = '{`PPFS_MASK_PAS_LOW_ANA, `PPFS_MASK_PAS_HIGH_ANA, `PPFS_MASK_PBS, `PPFS_MASK_INT_SRC};
    // address, select value, pad (8 up = port b), pad enable, {chan, vref}
    localparam logic [30:0] ROUTES [18] = '{
        {LO,8'h01,4'd0,1'b1,6'h00}, {LO,8'h02,4'd0,1'b0,6'h02}, {LO,8'h03,4'd0,1'b0,6'h00},
        {LO,8'h04,4'd1,1'b1,6'h00}, {LO,8'h08,4'd1,1'b0,6'h01}, {LO,8'h0c,4'd1,1'b0,6'h04},
        {LO,8'h10,4'd2,1'b0,6'h08}, {LO,8'h40,4'd3,1'b0,6'h10}, {LO,8'h00,4'd3,1'b0,6'h00},
        {HI,8'h01,4'd4,1'b1,6'h00}, {HI,8'h04,4'd5,1'b1,6'h00}, {HI,8'h08,4'd5,1'b0,6'h20},
        {HI,8'h0c,4'd5,1'b0,6'h00}, {HI,8'h10,4'd6,1'b1,6'h00}, {HI,8'h00,4'd6,1'b0,6'h00},
        {PB,8'h20,4'd13,1'b1,6'h00}, {PB,8'h02,4'd9,1'b1,6'h00}, {PB,8'h01,4'd8,1'b1,6'h00}};

    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep_mode = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [7:0]  pa_in, pb_in, pa_ext = 8'hff, pb_ext = 8'hff;
    logic        pready, pslverr, pwm_a_output, pwm_a_inverted_output, pwm_b_output, pwm_c_output;
    logic        ext_int_input, timer_clock_input, wake_up;
    ppfs_pads_s  pa_pads, pb_pads;
    ppfs_ana_s   analog_conn;
    int          failures = 0, checks = 0;

    ppfs_top #(.ANALOG_VARIANT(1'b1)) uut (.*);
    ppfs_pad_model u_pads (.*);

    // 40 mhz clock
    always #12.5 pclk = ~pclk;

    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        `CHK(n < 20, 1'b1)
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        `CHK({e, r}, {1'b0, 24'h0, x})
    endtask

    // reset values, unused select bits, unmapped address
    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        for (int i = 0; i < 12; i++)
            rd(12'(i * 4), (i < 4 || i > 9) ? 8'hff : 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            wr(SA[i], 32'hff);
            rd(SA[i], SM[i]);
            wr(SA[i], 32'h0);
        end
        apb(1'b0, 12'h0fc, 32'h0, r, e);
        `CHK({e, r}, {1'b1, 32'h0})
        $display("regs done");
    endtask

    // direction, untouched latch drives high, bit set and clear
    task automatic t_output();
        wr(`PPFS_OFF_PA_DIR, 32'h0);
        repeat (2) @(posedge pclk);
        `CHK(pa_pads, 16'hffff)
        wr(`PPFS_OFF_PA_DATA, 32'h5a);
        wr(`PPFS_OFF_PA_DIR, 32'hf0);
        pa_ext <= 8'h3c;
        repeat (4) @(posedge pclk);
        `CHK(pa_pads.oe, 8'h0f)
        rd(`PPFS_OFF_PA_DATA, 8'h3a);
        wr(`PPFS_OFF_BIT_OP, 32'h100);
        wr(`PPFS_OFF_PA_DIR, 32'h0);
        repeat (2) @(posedge pclk);
        `CHK(pa_pads.out, 8'h3b)
        wr(`PPFS_OFF_BIT_OP, 32'h37);
        rd(`PPFS_OFF_PB_DIR, 8'h7f);
        wr(`PPFS_OFF_PA_DIR, 32'hff);
        $display("output done");
    endtask

    // every non-zero select code, plus zero for pad3 and pad6: pad enable and analogue connections
    task automatic t_routes();
        logic [11:0] a;
        logic [7:0]  d;
        logic [3:0]  p;
        logic        o;
        logic [5:0]  an;
        foreach (ROUTES[i])
        begin
            {a, d, p, o, an} = ROUTES[i];
            wr(a, {24'h0, d});
            repeat (3) @(posedge pclk);
            `CHK({p[3] ? pb_pads.oe[p[2:0]] : pa_pads.oe[p[2:0]], analog_conn}, {o, an})
        end
        $display("routes done");
    endtask

    // interrupt pad choice and timer clock pad
    task automatic t_int();
        wr(`PPFS_OFF_PA_DIR, 32'hff);
        pa_ext <= 8'h44;
        repeat (5) @(posedge pclk);
        `CHK({ext_int_input, timer_clock_input}, 2'b01)
        wr(IS, 32'h1);
        repeat (5) @(posedge pclk);
        `CHK(ext_int_input, 1'b1)
        pa_ext <= 8'h08;
        repeat (5) @(posedge pclk);
        `CHK({ext_int_input, timer_clock_input}, 2'b00)
        wr(IS, 32'h0);
        repeat (5) @(posedge pclk);
        `CHK(ext_int_input, 1'b1)
        $display("int done");
    endtask

    // watch eight cycles for a wake pulse
    task automatic watch_wake(input logic x);
        logic seen;
        seen = 1'b0;
        repeat (8)
        begin
            @(posedge pclk);
            seen = seen | wake_up;
        end
        `CHK(seen, x)
    endtask

    // wake on enabled falling pads only while asleep
    task automatic t_wake();
        wr(`PPFS_OFF_PA_WAKE, 32'h81);
        pa_ext     <= 8'hff;
        sleep_mode <= 1'b1;
        repeat (4) @(posedge pclk);
        pa_ext <= 8'h7f;
        watch_wake(1'b1);
        pa_ext <= 8'h7d;
        watch_wake(1'b0);
        pa_ext <= 8'h7c;
        watch_wake(1'b1);
        sleep_mode <= 1'b0;
        pa_ext     <= 8'hff;
        repeat (4) @(posedge pclk);
        pa_ext <= 8'hfe;
        watch_wake(1'b0);
        $display("wake done");
    endtask

    task automatic print_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // main sequence after four reset cycles
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_regs();
        t_output();
        t_routes();
        t_int();
        t_wake();
        print_verdict();
    end

    // watchdog well beyond the expected run
    initial
    begin
        #100000;
        $display("ERROR %0t watchdog expired", $time);
        failures++;
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
